/* File: logic/sis_params.svh */
// Purpose: constants of the status indicator sequencer
// Assumes: 125 MHz clock, register index addressing
// Notes:   all timing in ms ticks unless stated
`ifndef SIS_PARAMS_SVH
`define SIS_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define SIS_CLK_NS 8
`define SIS_TICK_NS 1000000
`define SIS_TICK_CYC (`SIS_TICK_NS / `SIS_CLK_NS)
`define SIS_FLASH_MS 8'hfa
`define SIS_BEEP_MS 8'h50
`define SIS_GAP_MS 8'h50

// ----------------------------------------
// register indices
// ----------------------------------------
`define SIS_REG_CTRL 4'h0
`define SIS_REG_SCAN_PER 4'h1
`define SIS_REG_SAME_TO 4'h2
`define SIS_REG_STATE 4'h3
`define SIS_REG_IRQ_STAT 4'h4
`define SIS_REG_IRQ_CLR 4'h5
`define SIS_REG_IRQ_EN 4'h6

// ----------------------------------------
// control bits and reset values
// ----------------------------------------
`define SIS_CTRL_IR_SLEEP 0
`define SIS_CTRL_TO_BEEP 1
`define SIS_CTRL_RST 3'h0
`define SIS_SCAN_PER_RST 16'h1388
`define SIS_SAME_TO_RST 16'h01f4

// ----------------------------------------
// interrupt event bits
// ----------------------------------------
`define SIS_EV_READ 0
`define SIS_EV_BAD 1
`define SIS_EV_TO 2
`define SIS_EV_SLEEP 3
`define SIS_EV_WAKE 4
`define SIS_EV_FAULT 5
`define SIS_EV_W 6

`endif

/* File: logic/sis_pkg.sv */
// Purpose: types of the status indicator sequencer
// Assumes: nothing
// Notes:   states are gray along boot-intro-scan-sleep-wake
package sis_pkg;
	typedef enum logic [2:0] {
		SIS_BOOT = 3'h0,
		SIS_INTRO = 3'h1,
		SIS_SCAN = 3'h3,
		SIS_SLEEP = 3'h2,
		SIS_WAKE = 3'h6,
		SIS_FAULT = 3'h4
	} sis_state_t;
endpackage : sis_pkg

/* File: logic/sis_top.sv */
// Purpose: drives status LEDs, beeper and laser from scanner events
// Assumes: all inputs synchronous to clk_i
// Notes:   1 ms tick from divider; beeps queue, never cut short
//
// How it works
// - healthy power-up: both LEDs, one beep, green flashes
// - program entry: three beeps, green flashes throughout
// - program exit: three beeps, green flash stops
// - enabled comm timeout gives three beeps
// - laser failure: red flashes, one error tone
// - motor failure: both flash, two error tones
// - electronic failure: continuous error tone, LEDs dark
// - config memory failure: three beeps at power-up
// - inactivity sends dormant; object in field wakes
// - red lit while laser on, off at expiry
// - good read: green flash, then one beep
// - host not ready: green steady until sent
// - program mode: steady red, error tone on bad label
// - waiting for host: green steady
// - waking from dormant: green flashes
// - same symbol suppressed within same-symbol timeout
`timescale 1ns/1ps
`include "sis_params.svh"

module sis_top #(
	parameter int unsigned TICK_CYC = `SIS_TICK_CYC,
	parameter logic [7:0] FLASH_MS = `SIS_FLASH_MS,
	parameter logic [7:0] BEEP_MS = `SIS_BEEP_MS,
	parameter logic [7:0] GAP_MS = `SIS_GAP_MS
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// self-test results, valid with done pulse
	input wire logic selftest_done_i,
	input wire logic laser_fail_i,
	input wire logic motor_fail_i,
	input wire logic elec_fail_i,
	input wire logic cfg_fail_i,
	// scanner events
	input wire logic prog_mode_i,
	input wire logic bad_label_i,
	input wire logic good_read_i,
	input wire logic [7:0] symbol_id_i,
	input wire logic comm_timeout_i,
	input wire logic host_ready_i,
	input wire logic ir_presence_i,
	input wire logic motor_ready_i,
	// indicators and actuators
	output logic led_red_o,
	output logic led_green_o,
	output logic beeper_o,
	output logic razz_o,
	output logic laser_diode_o,
	output logic motor_en_o,
	output logic irq_o
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	sis_pkg::sis_state_t state_ff; // main sequence
	logic [16:0] tick_cnt_ff; // ms divider
	logic tick_ff; // 1 ms enable
	logic [7:0] flash_cnt_ff; // flash half period
	logic flash_ff; // shared blink phase
	logic [2:0] ctrl_ff; // control bits
	logic [15:0] scan_per_ff; // inactivity limit, ms
	logic [15:0] same_to_ff; // same-symbol window, ms
	logic [`SIS_EV_W-1:0] irq_stat_ff; // sticky events
	logic [`SIS_EV_W-1:0] irq_en_ff; // event mask
	logic f_laser_ff, f_motor_ff, f_elec_ff; // fault latches
	logic [15:0] idle_ff; // ms since last activity
	logic prog_q_ff; // last program mode level
	logic [7:0] last_sym_ff; // last reported symbol
	logic sym_vld_ff; // last_sym_ff holds a symbol
	logic [15:0] same_tmr_ff; // same-symbol countdown
	logic [7:0] gflash_ff; // single green flash time
	logic beep_after_ff; // beep owed after flash
	logic tx_pend_ff; // data waits for host
	logic [3:0] beep_cnt_ff; // queued normal beeps
	logic [3:0] razz_cnt_ff; // queued error tones
	logic [7:0] tone_tmr_ff; // tone on or gap time
	logic tone_on_ff; // tone sounding
	logic tone_razz_ff; // tone is error kind
	logic [2:0] beep_add, razz_add; // tones queued now
	logic accept; // good read to report
	logic sleep_go; // enter dormant
	logic prog_edge; // program mode changed
	logic any_ev; // good read, bad label or program change this cycle
	logic [`SIS_EV_W-1:0] ev; // events this cycle
	logic tone_start; // player takes a tone
	logic tone_pick_razz; // that tone is an error

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// saturating queue add
	function automatic logic [3:0] q_add(input logic [3:0] c,
		input logic [2:0] n, input logic take);
		logic [4:0] s;
		s = {1'b0, c} + {2'b00, n} - {4'h0, take};
		q_add = s[4] ? 4'hf : s[3:0];
	endfunction : q_add

	// ms countdown
	function automatic logic [15:0] dn16(input logic [15:0] v);
		dn16 = (v == 16'h0) ? 16'h0 : v - 16'h1;
	endfunction : dn16

	// ----------------------------------------
	// timebase
	// ----------------------------------------
	// divider producing the 1 ms enable
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tick_cnt_ff <= 17'h0;
			tick_ff <= 1'b0;
		end else if (tick_cnt_ff == 17'(TICK_CYC - 1)) begin
			tick_cnt_ff <= 17'h0;
			tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 17'h1;
			tick_ff <= 1'b0;
		end
	end

	// common blink phase for every flashing LED
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flash_cnt_ff <= 8'h0;
			flash_ff <= 1'b1;
		end else if (tick_ff) begin
			if (flash_cnt_ff >= FLASH_MS - 8'h1) begin
				flash_cnt_ff <= 8'h0;
				flash_ff <= ~flash_ff;
			end else begin
				flash_cnt_ff <= flash_cnt_ff + 8'h1;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// software-written configuration
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_ff <= `SIS_CTRL_RST;
			scan_per_ff <= `SIS_SCAN_PER_RST;
			same_to_ff <= `SIS_SAME_TO_RST;
			irq_en_ff <= '0;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`SIS_REG_CTRL: ctrl_ff <= reg_wdata_i[2:0];
				`SIS_REG_SCAN_PER: scan_per_ff <= reg_wdata_i;
				`SIS_REG_SAME_TO: same_to_ff <= reg_wdata_i;
				`SIS_REG_IRQ_EN:
					irq_en_ff <= reg_wdata_i[`SIS_EV_W-1:0];
				default: ; // others read-only or ignored
			endcase
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 16'h0;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`SIS_REG_CTRL: reg_rdata_o <= {13'h0, ctrl_ff};
				`SIS_REG_SCAN_PER: reg_rdata_o <= scan_per_ff;
				`SIS_REG_SAME_TO: reg_rdata_o <= same_to_ff;
				`SIS_REG_STATE: reg_rdata_o <= {7'h0, tx_pend_ff,
					prog_q_ff, f_elec_ff, f_motor_ff, f_laser_ff,
					1'b0, state_ff};
				`SIS_REG_IRQ_STAT:
					reg_rdata_o <= {10'h0, irq_stat_ff};
				`SIS_REG_IRQ_EN: reg_rdata_o <= {10'h0, irq_en_ff};
				default: reg_rdata_o <= 16'h0; // unmapped
			endcase
		end else begin
			reg_rdata_o <= 16'h0;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// sticky status; a new event beats a clear
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_stat_ff <= '0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~((reg_wr_i &&
				reg_addr_i == `SIS_REG_IRQ_CLR) ?
				reg_wdata_i[`SIS_EV_W-1:0] : '0)) | ev;
		end
	end

	// level interrupt from a flop
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_ff & irq_en_ff);
		end
	end

	// ----------------------------------------
	// event decode
	// ----------------------------------------
	assign prog_edge = (state_ff == sis_pkg::SIS_SCAN) &&
		(prog_mode_i != prog_q_ff);
	// repeat of the same label inside the window is dropped
	assign accept = good_read_i && state_ff == sis_pkg::SIS_SCAN &&
		!(sym_vld_ff && symbol_id_i == last_sym_ff &&
		same_tmr_ff != 16'h0);
	assign sleep_go = state_ff == sis_pkg::SIS_SCAN && tick_ff &&
		ctrl_ff[`SIS_CTRL_IR_SLEEP] && !prog_q_ff && !tx_pend_ff &&
		idle_ff >= scan_per_ff;
	assign any_ev = accept || bad_label_i || prog_edge;

	// interrupt events of this cycle
	always_comb begin
		ev = '0;
		ev[`SIS_EV_READ] = accept;
		ev[`SIS_EV_BAD] = bad_label_i && prog_q_ff &&
			state_ff == sis_pkg::SIS_SCAN;
		ev[`SIS_EV_TO] = comm_timeout_i &&
			state_ff == sis_pkg::SIS_SCAN;
		ev[`SIS_EV_SLEEP] = sleep_go;
		ev[`SIS_EV_WAKE] = state_ff == sis_pkg::SIS_WAKE &&
			motor_ready_i;
		ev[`SIS_EV_FAULT] = state_ff == sis_pkg::SIS_BOOT &&
			selftest_done_i && (laser_fail_i || motor_fail_i ||
			elec_fail_i || cfg_fail_i);
	end

	// tones requested this cycle; only the highest-priority beep source counts, error tones apart
	always_comb begin
		beep_add = 3'h0;
		razz_add = 3'h0;
		if (state_ff == sis_pkg::SIS_BOOT && selftest_done_i) begin
			if (elec_fail_i) begin
				razz_add = 3'h0; // continuous tone instead
			end else if (motor_fail_i) begin
				razz_add = 3'h2;
			end else if (laser_fail_i) begin
				razz_add = 3'h1;
			end else if (cfg_fail_i) begin
				beep_add = 3'h3;
			end else begin
				beep_add = 3'h1;
			end
		end else if (state_ff == sis_pkg::SIS_SCAN) begin
			if (prog_edge) begin
				beep_add = 3'h3;
			end else if (comm_timeout_i &&
				ctrl_ff[`SIS_CTRL_TO_BEEP]) begin
				beep_add = 3'h3;
			end else if (beep_after_ff && gflash_ff == 8'h1 &&
				tick_ff) begin
				beep_add = 3'h1; // beep follows flash
			end
			if (bad_label_i && prog_q_ff) begin
				razz_add = 3'h1;
			end
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	// power-up, scanning, dormancy and wake
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= sis_pkg::SIS_BOOT;
		end else begin
			case (state_ff)
				sis_pkg::SIS_BOOT: begin
					if (selftest_done_i) begin
						if (elec_fail_i || motor_fail_i ||
							laser_fail_i) begin
							state_ff <= sis_pkg::SIS_FAULT;
						end else begin
							state_ff <= sis_pkg::SIS_INTRO;
						end
					end
				end
				sis_pkg::SIS_INTRO: begin
					// ready once the start-up tones are done
					if (beep_cnt_ff == 4'h0 && !tone_on_ff &&
						tone_tmr_ff == 8'h0) begin
						state_ff <= sis_pkg::SIS_SCAN;
					end
				end
				sis_pkg::SIS_SCAN: begin
					if (sleep_go) begin
						state_ff <= sis_pkg::SIS_SLEEP;
					end
				end
				sis_pkg::SIS_SLEEP: begin
					if (ir_presence_i) begin
						state_ff <= sis_pkg::SIS_WAKE;
					end
				end
				sis_pkg::SIS_WAKE: begin
					if (motor_ready_i) begin
						state_ff <= sis_pkg::SIS_SCAN;
					end
				end
				sis_pkg::SIS_FAULT: ; // held until power cycle
				default: state_ff <= sis_pkg::SIS_BOOT;
			endcase
		end
	end

	// failure latches, caught at the self-test pulse
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			f_laser_ff <= 1'b0;
			f_motor_ff <= 1'b0;
			f_elec_ff <= 1'b0;
		end else if (state_ff == sis_pkg::SIS_BOOT &&
			selftest_done_i) begin
			f_elec_ff <= elec_fail_i;
			f_motor_ff <= motor_fail_i && !elec_fail_i;
			f_laser_ff <= laser_fail_i && !motor_fail_i &&
				!elec_fail_i;
		end
	end

	// inactivity counter and program mode tracking
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			idle_ff <= 16'h0;
			prog_q_ff <= 1'b0;
		end else begin
			if (state_ff == sis_pkg::SIS_SCAN) begin
				prog_q_ff <= prog_mode_i;
			end
			if (state_ff != sis_pkg::SIS_SCAN || any_ev ||
				sleep_go) begin
				idle_ff <= 16'h0;
			end else if (tick_ff && idle_ff != 16'hffff) begin
				idle_ff <= idle_ff + 16'h1;
			end
		end
	end

	// read reporting: same-symbol window, flash, host wait
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			last_sym_ff <= 8'h0;
			sym_vld_ff <= 1'b0;
			same_tmr_ff <= 16'h0;
			gflash_ff <= 8'h0;
			beep_after_ff <= 1'b0;
			tx_pend_ff <= 1'b0;
		end else begin
			if (good_read_i && state_ff == sis_pkg::SIS_SCAN) begin
				last_sym_ff <= symbol_id_i;
				sym_vld_ff <= 1'b1;
				same_tmr_ff <= same_to_ff; // restarts on repeats
			end else if (tick_ff) begin
				same_tmr_ff <= dn16(same_tmr_ff);
			end
			if (accept) begin
				gflash_ff <= FLASH_MS;
				beep_after_ff <= 1'b1;
			end else if (tick_ff && gflash_ff != 8'h0) begin
				gflash_ff <= gflash_ff - 8'h1;
				if (gflash_ff == 8'h1) begin
					beep_after_ff <= 1'b0;
				end
			end
			if (accept) begin
				tx_pend_ff <= 1'b1;
			end else if (host_ready_i) begin
				tx_pend_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// tone player
	// ----------------------------------------
	assign tone_start = !tone_on_ff && tone_tmr_ff == 8'h0 &&
		(razz_cnt_ff != 4'h0 || beep_cnt_ff != 4'h0);
	assign tone_pick_razz = razz_cnt_ff != 4'h0; // errors first

	// queues; requests beyond a count of 15 are dropped
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			beep_cnt_ff <= 4'h0;
			razz_cnt_ff <= 4'h0;
		end else begin
			beep_cnt_ff <= q_add(beep_cnt_ff, beep_add,
				tone_start && !tone_pick_razz);
			razz_cnt_ff <= q_add(razz_cnt_ff, razz_add,
				tone_start && tone_pick_razz);
		end
	end

	// each tone sounds BEEP_MS then rests GAP_MS
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tone_on_ff <= 1'b0;
			tone_razz_ff <= 1'b0;
			tone_tmr_ff <= 8'h0;
		end else if (tone_start) begin
			tone_on_ff <= 1'b1;
			tone_razz_ff <= tone_pick_razz;
			tone_tmr_ff <= BEEP_MS;
		end else if (tick_ff) begin
			if (tone_tmr_ff > 8'h1) begin
				tone_tmr_ff <= tone_tmr_ff - 8'h1;
			end else if (tone_on_ff) begin
				tone_on_ff <= 1'b0;
				tone_tmr_ff <= GAP_MS;
			end else begin
				tone_tmr_ff <= 8'h0;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// LED, beeper, laser and motor drive
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			led_red_o <= 1'b0;
			led_green_o <= 1'b0;
			beeper_o <= 1'b0;
			razz_o <= 1'b0;
			laser_diode_o <= 1'b0;
			motor_en_o <= 1'b0;
		end else begin
			beeper_o <= tone_on_ff;
			razz_o <= tone_on_ff && tone_razz_ff;
			laser_diode_o <= 1'b0;
			motor_en_o <= 1'b0;
			led_red_o <= 1'b0;
			led_green_o <= 1'b0;
			case (state_ff)
				sis_pkg::SIS_INTRO: begin
					led_red_o <= 1'b1;
					led_green_o <= flash_ff;
					motor_en_o <= 1'b1;
				end
				sis_pkg::SIS_SCAN: begin
					laser_diode_o <= 1'b1;
					motor_en_o <= 1'b1;
					led_red_o <= 1'b1; // follows laser
					if (prog_q_ff) begin
						led_green_o <= flash_ff;
					end else begin
						led_green_o <= gflash_ff != 8'h0 ||
							tx_pend_ff;
					end
				end
				sis_pkg::SIS_WAKE: begin
					motor_en_o <= 1'b1; // spin-up
					led_green_o <= flash_ff;
				end
				sis_pkg::SIS_FAULT: begin
					if (f_elec_ff) begin
						beeper_o <= 1'b1;
						razz_o <= 1'b1; // LEDs stay dark
					end else begin
						led_red_o <= flash_ff;
						led_green_o <= f_motor_ff && flash_ff;
					end
				end
				default: ; // boot and sleep: all dark
			endcase
		end
	end

endmodule : sis_top

/* File: tb/sis_top_asserts.sv */
// Purpose: port-level checks of the indicator sequencer
// Assumes: bound into sis_top, one clock domain
// Notes:   tone and gap lengths judged by run counters
`timescale 1ns/1ps

module sis_top_asserts #(
	parameter int unsigned TICK_CYC = 10,
	parameter logic [7:0] BEEP_MS = 8'h02,
	parameter logic [7:0] GAP_MS = 8'h02
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register port
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	// events
	input wire logic prog_mode_i,
	input wire logic host_ready_i,
	// indicators
	input wire logic led_red_o,
	input wire logic led_green_o,
	input wire logic beeper_o,
	input wire logic razz_o,
	input wire logic laser_diode_o
);
	localparam int TLO = (BEEP_MS - 1) * TICK_CYC; // shortest tone
	localparam int THI = (BEEP_MS + 1) * TICK_CYC; // longest tone
	localparam int GLO = (GAP_MS - 1) * TICK_CYC; // shortest silence
	localparam int LIM = 2 * (THI + GLO) + 8; // wait for a queued tone

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// --------------------------------
	// run lengths of tone and silence
	// --------------------------------
	int on_cnt_ff; // cycles the beeper has been on
	int off_cnt_ff; // cycles the beeper has been off

	// on-run counter
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) on_cnt_ff <= 0;
		else on_cnt_ff <= beeper_o ? on_cnt_ff + 1 : 0;
	end

	// off-run counter, starts long so the first tone passes
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) off_cnt_ff <= GLO;
		else off_cnt_ff <= beeper_o ? 0 : off_cnt_ff + 1;
	end

	// change of programming mode while quiet and lit
	sequence s_prog_edge;
		$changed(prog_mode_i) && led_red_o && !beeper_o;
	endsequence

	// --------------------------------
	// assertions
	// --------------------------------
	chk_boot_quiet: assert property ($past(sys_rst_i) |->
		!beeper_o && !led_red_o && !led_green_o && !laser_diode_o)
		else $error("outputs active right after reset");
	chk_rdata_idle: assert property (!$past(reg_rd_i) |->
		reg_rdata_o == 16'h0000) else $error("read data outside slot");
	chk_razz_tone: assert property (razz_o |-> beeper_o)
		else $error("error tone without beeper");
	chk_tone_len: assert property ($fell(beeper_o) |->
		on_cnt_ff >= TLO && on_cnt_ff <= THI)
		else $error("tone length wrong");
	chk_gap_min: assert property ($rose(beeper_o) |->
		off_cnt_ff >= GLO) else $error("tone spacing too short");
	chk_long_tone: assert property (on_cnt_ff > THI |->
		razz_o && !led_red_o && !led_green_o)
		else $error("continuous tone outside electronic fault");
	chk_laser_red: assert property (
		laser_diode_o && $past(laser_diode_o, 2) |-> led_red_o)
		else $error("red dark while laser on");
	chk_sleep_dark: assert property ($fell(laser_diode_o) |->
		##[0:2] !led_red_o && !led_green_o)
		else $error("leds lit after laser off");
	chk_prog_beep: assert property (s_prog_edge |->
		##[1:LIM] beeper_o) else $error("no beeps on program change");
	chk_tx_green: assert property (
		$fell(led_green_o) && laser_diode_o && !prog_mode_i |->
		$past(host_ready_i)) else $error("green off while host busy");
endmodule : sis_top_asserts

/* File: tb/sis_host_model.sv */
// Purpose: host that accepts scanned data, promptly or late
// Assumes: bench raises busy_i to stall the host
// Notes:   readiness returns LAG cycles after the stall ends
`timescale 1ns/1ps

module sis_host_model #(
	parameter int LAG = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// bench control
	input wire logic busy_i,
	// to the scanner
	output logic host_ready_o
);
	int lag_ff; // cycles since the stall was lifted

	// slow recovery after a stall
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) lag_ff <= LAG;
		else if (busy_i) lag_ff <= 0;
		else if (lag_ff < LAG) lag_ff <= lag_ff + 1;
	end

	// ready only once the lag has run out
	assign host_ready_o = !busy_i && lag_ff >= LAG;
endmodule : sis_host_model

/* File: tb/sis_top_tb_top.sv */
// Purpose: self-checking bench of the indicator sequencer
// Assumes: 1 ms shrunk to 10 cycles, tones and flashes of 2 ms
// Notes:   outputs sampled on falling edges
`timescale 1ns/1ps
`include "sis_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module sis_top_tb_top;
	localparam int unsigned TC = 10; // cycles per ms tick
	logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, busy = 0;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000, rd_d, reg_rdata_o;
	logic [7:0] symbol_id_i = 8'h00;
	logic selftest_done_i = 0, laser_fail_i = 0, motor_fail_i = 0;
	logic elec_fail_i = 0, cfg_fail_i = 0, prog_mode_i = 0;
	logic bad_label_i = 0, good_read_i = 0, comm_timeout_i = 0;
	logic ir_presence_i = 0, motor_ready_i = 0, pb, pg, pr;
	logic led_red_o, led_green_o, beeper_o, razz_o, laser_diode_o;
	logic motor_en_o, irq_o;
	wire host_ready_i;
	int mismatches = 0, n_checks = 0, cyc = 0;
	int n_beep, n_razz, n_gtog, n_rtog, n_ron, n_gon; // observed counts

	always #4 clk_i = ~clk_i;

	sis_top #(.TICK_CYC(TC), .FLASH_MS(8'h02), .BEEP_MS(8'h02),
		.GAP_MS(8'h02)) DUT (.*);
	sis_host_model #(.LAG(4)) u_host (.clk_i, .sys_rst_i, .busy_i(busy),
		.host_ready_o(host_ready_i));

	// --------------------------------
	// closing and hang guard
	// --------------------------------
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	// --------------------------------
	// bus and observation tasks
	// --------------------------------
	task wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr

	task rd(input logic [3:0] a);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		rd_d = reg_rdata_o;
		@(posedge clk_i);
	endtask : rd

	// count tones and led changes over n cycles
	task run(input int n, input bit keep);
		if (!keep) begin
			{n_beep, n_razz, n_gtog, n_rtog, n_ron, n_gon} = '0;
			{pb, pg, pr} = {beeper_o, led_green_o, led_red_o};
		end
		repeat (n) begin
			@(negedge clk_i);
			n_beep += beeper_o && !pb && !razz_o;
			n_razz += beeper_o && !pb && razz_o;
			n_gtog += led_green_o != pg;
			n_rtog += led_red_o != pr;
			n_ron += led_red_o;
			n_gon += led_green_o;
			{pb, pg, pr} = {beeper_o, led_green_o, led_red_o};
		end
		@(posedge clk_i);
	endtask : run

	// reset, then report self-test result f
	task boot(input logic [3:0] f);
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		{laser_fail_i, motor_fail_i, elec_fail_i, cfg_fail_i} <= f;
		@(posedge clk_i);
		selftest_done_i <= 1'b1;
		@(posedge clk_i);
		selftest_done_i <= 1'b0;
		run(300, 0);
	endtask : boot

	task read_sym(input logic [7:0] s);
		symbol_id_i <= s;
		good_read_i <= 1'b1;
		@(posedge clk_i);
		good_read_i <= 1'b0;
	endtask : read_sym

	// --------------------------------
	// scenarios
	// --------------------------------
	task t_boot;
		boot(4'h0);
		`CHK(n_beep, 1)
		`CHK({n_gtog > 0, n_ron > 0, laser_diode_o}, 3'h7)
	endtask : t_boot

	task t_regs;
		rd(`SIS_REG_CTRL);
		`CHK(rd_d, 16'h0000)
		rd(`SIS_REG_SCAN_PER);
		`CHK(rd_d, `SIS_SCAN_PER_RST)
		rd(`SIS_REG_SAME_TO);
		`CHK(rd_d, `SIS_SAME_TO_RST)
		wr(`SIS_REG_STATE, 16'hffff);
		rd(`SIS_REG_STATE);
		`CHK(rd_d[2:0], 3'h3)
		rd(4'hf);
		`CHK(rd_d, 16'h0000)
		wr(`SIS_REG_SAME_TO, 16'h0003);
		rd(`SIS_REG_SAME_TO);
		`CHK(rd_d, 16'h0003)
	endtask : t_regs

	task t_read;
		read_sym(8'h41);
		run(10, 0);
		`CHK(led_green_o, 1'b1)
		read_sym(8'h41);
		run(100, 1);
		`CHK({n_beep, n_gtog}, {32'd1, 32'd2})
		read_sym(8'h41);
		run(100, 0);
		`CHK(n_beep, 1)
		rd(`SIS_REG_IRQ_STAT);
		`CHK({rd_d[`SIS_EV_READ], irq_o}, 2'h2)
		wr(`SIS_REG_IRQ_EN, 16'h0001);
		run(2, 0);
		`CHK(irq_o, 1'b1)
		wr(`SIS_REG_IRQ_CLR, 16'h0001);
		run(2, 0);
		`CHK(irq_o, 1'b0)
		wr(`SIS_REG_IRQ_EN, 16'h0000);
		busy <= 1'b1;
		read_sym(8'h42);
		run(150, 0);
		`CHK({n_beep, n_ron}, {32'd1, 32'd150})
		`CHK(led_green_o, 1'b1)
		rd(`SIS_REG_STATE);
		`CHK(rd_d[8], 1'b1)
		busy <= 1'b0;
		run(20, 0);
		`CHK(led_green_o, 1'b0)
	endtask : t_read

	task t_prog;
		prog_mode_i <= 1'b1;
		run(200, 0);
		`CHK({n_beep, n_ron}, {32'd3, 32'd200})
		`CHK(n_gtog > 4, 1'b1)
		bad_label_i <= 1'b1;
		@(posedge clk_i);
		bad_label_i <= 1'b0;
		run(80, 0);
		`CHK(n_razz, 1)
		prog_mode_i <= 1'b0;
		run(200, 0);
		`CHK(n_beep, 3)
		run(60, 0);
		`CHK(n_gtog, 0)
	endtask : t_prog

	task t_tout(input logic [15:0] ctl, input int exp);
		wr(`SIS_REG_CTRL, ctl);
		comm_timeout_i <= 1'b1;
		@(posedge clk_i);
		comm_timeout_i <= 1'b0;
		run(150, 0);
		`CHK(n_beep, exp)
	endtask : t_tout

	task t_sleep;
		wr(`SIS_REG_SCAN_PER, 16'h0005);
		wr(`SIS_REG_CTRL, 16'h0001);
		run(120, 0);
		`CHK({laser_diode_o, led_red_o, led_green_o, motor_en_o}, 4'h0)
		ir_presence_i <= 1'b1;
		run(60, 0);
		`CHK({motor_en_o, n_gtog > 1}, 2'h3)
		rd(`SIS_REG_STATE);
		`CHK(rd_d[2:0], 3'h6)
		wr(`SIS_REG_CTRL, 16'h0000);
		motor_ready_i <= 1'b1;
		ir_presence_i <= 1'b0;
		run(10, 0);
		`CHK(laser_diode_o, 1'b1)
		rd(`SIS_REG_IRQ_STAT);
		`CHK(rd_d[4:3], 2'h3)
		motor_ready_i <= 1'b0;
		run(120, 0);
		`CHK(laser_diode_o, 1'b1)
	endtask : t_sleep

	// laser, motor, electronic, laser with motor, config memory
	task automatic t_fault;
		logic [3:0] f [5] = '{4'h8, 4'h4, 4'h2, 4'hc, 4'h1};
		int ez [5] = '{1, 2, 1, 2, 0};
		for (int i = 0; i < 5; i++) begin
			boot(f[i]);
			`CHK(n_razz, ez[i])
			if (i == 0) `CHK({n_gon == 0, n_rtog > 2}, 2'h3)
			if (i == 1) `CHK({n_gtog > 2, n_rtog > 2}, 2'h3)
			if (i == 2)
				`CHK({beeper_o, razz_o, n_ron + n_gon}, 34'h3_0000_0000)
			if (i == 4) `CHK(n_beep, 3)
			rd(`SIS_REG_STATE);
			`CHK(rd_d[2:0], i == 4 ? 3'h3 : 3'h4)
		end
	endtask : t_fault

	initial begin
		t_boot();
		t_regs();
		t_read();
		t_prog();
		t_tout(16'h0000, 0);
		t_tout(16'h0002, 3);
		t_sleep();
		t_fault();
		end_of_test();
	end
endmodule : sis_top_tb_top

bind sis_top sis_top_asserts #(.TICK_CYC(TICK_CYC), .BEEP_MS(BEEP_MS),
	.GAP_MS(GAP_MS)) u_chk (.*);
